// ### dv/jpse_ecm_model.sv
// behavioural network node: takes requests, replies, and broadcasts on command
module jpse_ecm_model import jpse_pkg::*; (
  input wire logic clk,
  input wire logic canTxValid,
  input wire logic [ID_W-1:0] canTxId,
  input wire logic [63:0] canTxData,
  input wire logic [3:0] readyDelay,
  input wire logic wrongPgn,
  output logic canTxReady,
  output logic canRxValid,
  output logic canRxExt,
  output logic [ID_W-1:0] canRxId,
  output logic [3:0] canRxDlc,
  output logic [63:0] canRxData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PGN_W-1:0] pgn;
  initial begin
    canTxReady = 1'h0;
    canRxValid = 1'h0;
    canRxExt = 1'h0;
    canRxId = '0;
    canRxDlc = 4'h0;
    canRxData = '0;
  end
  // one frame; released id and data lines invert so stale values never look valid
  task automatic send(input logic ext, input logic [ID_W-1:0] id, input logic [63:0] d);
    @(posedge clk) #1;
    canRxValid = 1'h1;
    canRxExt = ext;
    canRxId = id;
    canRxDlc = 4'h8;
    canRxData = d;
    @(posedge clk) #1;
    canRxValid = 1'h0;
    canRxId = ~id;
    canRxData = ~d;
  endtask
  // stall the request, then answer from the addressed node
  always begin
    @(posedge clk);
    if (canTxValid === 1'h1) begin
      repeat (readyDelay) @(posedge clk);
      #1 canTxReady = 1'h1;
      // a wrong group flips a format bit, since the low byte of a pdu1 group is not decoded
      pgn = canTxData[PGN_W-1:0] ^ {9'h0, wrongPgn, 8'h0};
      @(posedge clk) #1 canTxReady = 1'h0;
      repeat (2) @(posedge clk);
      send(1'h1, {3'h6, pgn[17:8], (pgn[15:8] < PDU2_FIRST_PF) ? SRC_ADDR : pgn[7:0], canTxId[15:8]}, 64'(pgn));
    end
  end
endmodule

// ### dv/jpse_scan_engine_monitor.sv
// port checker for the scan engine, bound to its top
module jpse_scan_engine_chk import jpse_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic canRxValid,
  input wire logic canRxExt,
  input wire logic [ID_W-1:0] canRxId,
  input wire logic [63:0] canRxData,
  input wire logic canTxReady,
  input wire logic canBusOff,
  input wire logic canTxValid,
  input wire logic canTxExt,
  input wire logic [ID_W-1:0] canTxId,
  input wire logic [3:0] canTxDlc,
  input wire logic [BIT_CYC_W-1:0] canBitCycles,
  input wire logic hostValid,
  input wire logic [7:0] hostSrc,
  input wire logic [63:0] hostData,
  input wire logic ledGreen,
  input wire logic ledOrange
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // request frames: extended, own address, request group, fixed length
  property p_txId;
    canTxValid |-> canTxExt && canTxId[7:0] == SRC_ADDR && canTxId[25:16] == {2'h0, REQ_PF} && canTxDlc == REQ_DLC;
  endproperty
  a_txId: assert property (p_txId) else $error("bad request frame");
  // request stands unchanged until the controller takes it
  property p_hold;
    canTxValid && !canTxReady |=> canTxValid && $stable(canTxId);
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  // one request outstanding: taken request is withdrawn at once
  property p_drop;
    canTxValid && canTxReady |=> !canTxValid;
  endproperty
  a_drop: assert property (p_drop) else $error("request repeated");
  property p_rate;
    $past(rst_b) |-> canBitCycles == BIT_CYCLES;
  endproperty
  a_rate: assert property (p_rate) else $error("bit timing wrong");
  property p_std;
    canRxValid && !canRxExt |=> !hostValid;
  endproperty
  a_std: assert property (p_std) else $error("standard frame forwarded");
  // a record always carries the frame taken one cycle earlier
  property p_fwd;
    hostValid |-> $past(canRxValid && canRxExt) && hostData == $past(canRxData) && hostSrc == $past(canRxId[7:0]);
  endproperty
  a_fwd: assert property (p_fwd) else $error("record without frame");
  property p_green;
    $past(rst_b) |-> ledGreen == !$past(canBusOff);
  endproperty
  a_green: assert property (p_green) else $error("health lamp wrong");
  property p_flash;
    (canRxValid && canRxExt) || (canTxValid && canTxReady) |-> ##2 ledOrange;
  endproperty
  a_flash: assert property (p_flash) else $error("no traffic flash");
endmodule

bind jpse_scan_engine jpse_scan_engine_chk u_chk (.*);

// ### dv/jpse_scan_engine_tb_top.sv
// self-checking bench for the scan engine with a network node model
module jpse_scan_engine_tb_top import jpse_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, cfgWe, cfgEn, cfgMode, canBusOff, wrongPgn, canRxValid, canRxExt, canTxReady;
  logic canTxValid, canTxExt, hostValid, ledGreen, ledOrange;
  logic [3:0] cfgIdx, canRxDlc, canTxDlc, hostDlc, hostIdx, readyDelay;
  logic [7:0] cfgDest, hostSrc;
  logic [PGN_W-1:0] cfgPgn, hostPgn;
  logic [ID_W-1:0] canRxId, canTxId, txId;
  logic [63:0] canRxData, canTxData, hostData, txData;
  logic [BIT_CYC_W-1:0] canBitCycles;
  int n_mismatch, compares, nHost, nTx, n0, t0;
  // short flash and reply wait keep the run brief
  jpse_scan_engine #(.LED_FLASH_CYC(20), .REQ_TIMEOUT_CYC(50)) dut (.*);
  jpse_ecm_model ecm (.*);
  always #5 clk = ~clk;
  // count records and taken requests, keep the last request
  always @(posedge clk) begin
    if (hostValid === 1'h1) nHost <= nHost + 1;
    if (canTxValid === 1'h1 && canTxReady === 1'h1) begin
      nTx <= nTx + 1;
      txId <= canTxId;
      txData <= canTxData;
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for a record count
  task automatic wait_host(input int n);
    for (int i = 0; i < 400 && nHost < n; i++) @(posedge clk);
    #1;
    if (nHost < n) begin
      n_mismatch++;
      $display("ERROR at %0t: no record", $time);
      final_report();
    end
  endtask
  task automatic cfg(input logic [3:0] idx, input logic en, input logic md, input logic [PGN_W-1:0] pgn);
    @(posedge clk) #1;
    cfgWe = 1'h1;
    cfgIdx = idx;
    cfgEn = en;
    cfgMode = md;
    cfgPgn = pgn;
    @(posedge clk) #1;
    cfgWe = 1'h0;
  endtask
  task automatic t_reset();
    cyc(1);
    check(canBitCycles, BIT_CYCLES);
    check(canTxExt, 1'h1);
    check(ledGreen, 1'h1);
    check(ledOrange, 1'h0);
    check(canTxDlc, REQ_DLC);
    $display("reset test done");
  endtask
  // matching, standard-format and foreign frames against one monitor entry
  task automatic t_monitor();
    cfg(4'h2, 1'h1, JPSE_MODE_MONITOR, 18'h0FEF1);
    n0 = nHost;
    t0 = nTx;
    ecm.send(1'h1, {3'h6, 18'h0FEF1, 8'h33}, 64'h1122334455667788);
    ecm.send(1'h0, {3'h6, 18'h0FEF1, 8'h44}, 64'h0);
    ecm.send(1'h1, {3'h6, 18'h0FEF2, 8'h44}, 64'h0);
    cyc(30);
    check(nHost - n0, 1);
    check(hostIdx, 4'h2);
    check(hostPgn, 18'h0FEF1);
    check(hostSrc, 8'h33);
    check(hostData, 64'h1122334455667788);
    check(hostDlc, 4'h8);
    check(nTx - t0, 0);
    $display("monitor test done");
  endtask
  task automatic t_request();
    readyDelay = 4'h4;
    cfg(4'h5, 1'h1, JPSE_MODE_REQUEST, 18'h0C100);
    n0 = nHost;
    t0 = nTx;
    wait_host(n0 + 1);
    check(nTx - t0, 1);
    check(txId, {3'h6, 2'h0, REQ_PF, 8'h00, SRC_ADDR});
    check(txData, 64'h0C100);
    check(hostIdx, 4'h5);
    check(hostPgn, 18'h0C100);
    wait_host(n0 + 2);
    check(nTx - t0, 2);
    $display("request test done");
  endtask
  // replies with the wrong group must time out, and requests repeat
  task automatic t_wrong();
    wrongPgn = 1'h1;
    readyDelay = 4'h0;
    n0 = nHost;
    t0 = nTx;
    cyc(200);
    check(nHost - n0, 0);
    check(nTx - t0 > 2, 1'h1);
    wrongPgn = 1'h0;
    $display("reply match test done");
  endtask
  task automatic t_leds();
    canBusOff = 1'h1;
    cyc(2);
    check(ledGreen, 1'h0);
    canBusOff = 1'h0;
    cfg(4'h5, 1'h0, JPSE_MODE_REQUEST, 18'h0C100);
    cyc(150);
    check(ledOrange, 1'h0);
    ecm.send(1'h1, {3'h6, 18'h0FEF1, 8'h33}, 64'h5);
    cyc(2);
    check(ledOrange, 1'h1);
    check(hostData, 64'h5);
    $display("indicator test done");
  endtask
  // global target: any source may answer, group taken from a pdu2 identifier
  task automatic t_global();
    cfgDest = 8'hFF;
    cfg(4'h7, 1'h1, JPSE_MODE_REQUEST, 18'h0FECA);
    n0 = nHost;
    t0 = nTx;
    wait_host(n0 + 1);
    check(nTx - t0, 1);
    check(txId, {3'h6, 2'h0, REQ_PF, 8'hFF, SRC_ADDR});
    check(hostIdx, 4'h7);
    check(hostPgn, 18'h0FECA);
    check(hostSrc, 8'hFF);
    check(hostData, 64'h0FECA);
    $display("global request test done");
  endtask
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    cfgWe = 1'h0;
    cfgIdx = 4'h0;
    cfgEn = 1'h0;
    cfgMode = 1'h0;
    cfgPgn = 18'h0;
    cfgDest = 8'h00;
    canBusOff = 1'h0;
    readyDelay = 4'h0;
    wrongPgn = 1'h0;
    cyc(20);
    rst_b = 1'h1;
    t_reset();
    t_monitor();
    t_request();
    t_wrong();
    t_leds();
    t_global();
    final_report();
  end
endmodule

// ### hdl/jpse_pgn_extract.sv
// splits an extended identifier into group number, destination and source
module jpse_pgn_extract import jpse_pkg::*; (
  input wire logic [ID_W-1:0] id,
  output logic [PGN_W-1:0] pgn,
  output logic [7:0] dest,
  output logic [7:0] src
);

  // below the pdu2 boundary the low byte is a destination, not part of the group
  always_comb begin
    src = id[7:0];
    if (id[23:16] < PDU2_FIRST_PF) begin
      pgn = {id[25:16], 8'h00};
      dest = id[15:8];
    end else begin
      pgn = id[25:8];
      dest = GLOBAL_ADDR;
    end
  end

endmodule

// ### hdl/jpse_pkg.sv
// shared constants and types of the parameter-group scan engine
package jpse_pkg;

  // network framing
  localparam int ID_W = 29;
  localparam int PGN_W = 18;
  localparam logic [7:0] SRC_ADDR = 8'hFB;
  localparam logic [7:0] GLOBAL_ADDR = 8'hFF;
  localparam logic [7:0] PDU2_FIRST_PF = 8'hF0;
  localparam logic [7:0] REQ_PF = 8'hEA;
  localparam logic [PGN_W-1:0] REQ_PGN = 18'h0EA00;
  localparam logic [2:0] REQ_PRIO = 3'h6;
  localparam logic [3:0] REQ_DLC = 4'h3;

  // clock and bit timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BIT_RATE_BPS = 250_000;
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
  localparam int BIT_CYC_W = 16;

  // traffic flash and reply wait
  localparam int LED_FLASH_MS = 50;
  localparam int LED_FLASH_CYCLES = LED_FLASH_MS * (CLK_HZ / 1000);
  localparam int REQ_TIMEOUT_MS = 100;
  localparam int REQ_TIMEOUT_CYCLES = REQ_TIMEOUT_MS * (CLK_HZ / 1000);

  // gathering mode of one scan entry
  typedef enum logic {
    JPSE_MODE_MONITOR = 1'b0,
    JPSE_MODE_REQUEST = 1'b1
  } jpse_mode_e;

  // scan sequencer states, gray along pick-send-wait-gap
  typedef enum logic [1:0] {
    JPSE_ST_PICK = 2'h0,
    JPSE_ST_SEND = 2'h1,
    JPSE_ST_WAIT = 2'h3,
    JPSE_ST_GAP = 2'h2
  } jpse_state_e;

endpackage

// ### hdl/jpse_scan_engine.sv
// scan engine: gathers group data by monitoring or requesting, forwards it to the host
module jpse_scan_engine import jpse_pkg::*; #(
  parameter int ENTRIES = 16,
  parameter int LED_FLASH_CYC = LED_FLASH_CYCLES,
  parameter int REQ_TIMEOUT_CYC = REQ_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cfgWe,
  input wire logic [$clog2(ENTRIES)-1:0] cfgIdx,
  input wire logic cfgEn,
  input wire logic cfgMode,
  input wire logic [PGN_W-1:0] cfgPgn,
  input wire logic [7:0] cfgDest,
  input wire logic canRxValid,
  input wire logic canRxExt,
  input wire logic [ID_W-1:0] canRxId,
  input wire logic [3:0] canRxDlc,
  input wire logic [63:0] canRxData,
  input wire logic canTxReady,
  input wire logic canBusOff,
  output logic canTxValid,
  output logic canTxExt,
  output logic [ID_W-1:0] canTxId,
  output logic [3:0] canTxDlc,
  output logic [63:0] canTxData,
  output logic [BIT_CYC_W-1:0] canBitCycles,
  output logic hostValid,
  output logic [$clog2(ENTRIES)-1:0] hostIdx,
  output logic [PGN_W-1:0] hostPgn,
  output logic [7:0] hostSrc,
  output logic [3:0] hostDlc,
  output logic [63:0] hostData,
  output logic ledGreen,
  output logic ledOrange
);

  localparam int IW = $clog2(ENTRIES);
  localparam int LW = $clog2(LED_FLASH_CYC + 1);
  localparam int TW = $clog2(REQ_TIMEOUT_CYC + 1);
  localparam logic [IW-1:0] LAST_IDX = IW'(ENTRIES - 1);
  // both counts must be one or more: a zero reply wait would give up on every request at once

  // scan table, written by the host configuration port
  logic tblEn [ENTRIES];
  jpse_mode_e tblMode [ENTRIES];
  logic [PGN_W-1:0] tblPgn [ENTRIES];
  logic [7:0] tblDest [ENTRIES];

  // sequencer state and the request being served
  jpse_state_e state;
  jpse_state_e next_state;
  logic [IW-1:0] idx;
  logic [IW-1:0] next_idx;
  logic [PGN_W-1:0] pendPgn;
  logic [PGN_W-1:0] next_pendPgn;
  logic [7:0] pendDest;
  logic [7:0] next_pendDest;
  logic next_canTxValid;
  logic [ID_W-1:0] next_canTxId;
  logic [63:0] next_canTxData;
  logic next_hostValid;
  logic [IW-1:0] next_hostIdx;
  logic [PGN_W-1:0] next_hostPgn;
  logic [7:0] next_hostSrc;
  logic [3:0] next_hostDlc;
  logic [63:0] next_hostData;

  // decoded view of the frame now on the receive port
  logic [PGN_W-1:0] rxPgn;
  logic [7:0] rxDest;
  logic [7:0] rxSrc;
  logic rxOk;
  logic monHit;
  logic [IW-1:0] monIdx;
  logic replyHit;
  logic startWait;
  logic timeoutHit;
  logic waitBusy;
  logic trafficSeen;
  logic ledBusy;

  // table writes; one entry per cycle, mode stored exactly as configured
  // rewriting the pending entry leaves the outstanding request running to its end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tblEn[i] <= 1'b0;
        tblMode[i] <= JPSE_MODE_MONITOR;
        tblPgn[i] <= '0;
        tblDest[i] <= GLOBAL_ADDR;
      end
    end else if (cfgWe) begin
      tblEn[cfgIdx] <= cfgEn;
      tblMode[cfgIdx] <= jpse_mode_e'(cfgMode);
      tblPgn[cfgIdx] <= cfgPgn;
      tblDest[cfgIdx] <= cfgDest;
    end
  end

  jpse_pgn_extract u_rxPgn (
    .id(canRxId),
    .pgn(rxPgn),
    .dest(rxDest),
    .src(rxSrc)
  );

  // standard-format frames never reach the matcher
  assign rxOk = canRxValid && canRxExt;

  // monitor match over the whole table; lowest index wins on duplicates
  // disabled entries never match, whatever group they still hold
  always_comb begin
    monHit = 1'b0;
    monIdx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (tblEn[i] && tblMode[i] == JPSE_MODE_MONITOR && tblPgn[i] == rxPgn) begin
        monHit = 1'b1;
        monIdx = IW'(i);
      end
    end
  end

  // a reply must carry the pending group, come from the target (any source if the target is global), and be for us or global
  assign replyHit = rxOk && (state == JPSE_ST_WAIT) && (rxPgn == pendPgn)
    && (pendDest == GLOBAL_ADDR || rxSrc == pendDest)
    && (rxDest == SRC_ADDR || rxDest == GLOBAL_ADDR);

  // the timer loads on the accepted handshake, so the wait covers only the reply
  assign startWait = (state == JPSE_ST_SEND) && canTxReady;

  // reply wait: a silent target must not stall the scan forever
  jpse_timer #(
    .W(TW)
  ) u_replyTimer (
    .clk(clk),
    .rst_b(rst_b),
    .load(startWait),
    .loadVal(TW'(REQ_TIMEOUT_CYC)),
    .cancel(replyHit),
    .busy(waitBusy),
    .expired(timeoutHit)
  );

  // scan sequencer: monitor entries are skipped, only request entries transmit
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_pendPgn = pendPgn;
    next_pendDest = pendDest;
    next_canTxValid = canTxValid;
    next_canTxId = canTxId;
    next_canTxData = canTxData;
    case (state)
      JPSE_ST_PICK: begin
        if (tblEn[idx] && tblMode[idx] == JPSE_MODE_REQUEST) begin
          next_pendPgn = tblPgn[idx];
          next_pendDest = tblDest[idx];
          next_canTxValid = 1'b1;
          next_canTxId = {REQ_PRIO, 2'b00, REQ_PF, tblDest[idx], SRC_ADDR};
          next_canTxData = {40'h0, 6'h0, tblPgn[idx][17:16], tblPgn[idx][15:8], tblPgn[idx][7:0]};
          next_state = JPSE_ST_SEND;
        end else begin
          next_idx = (idx == LAST_IDX) ? '0 : idx + IW'(1);
        end
      end
      JPSE_ST_SEND: begin
        if (canTxReady) begin
          next_canTxValid = 1'b0;
          next_state = JPSE_ST_WAIT;
        end
      end
      JPSE_ST_WAIT: begin
        if (replyHit || timeoutHit || !waitBusy) begin
          next_state = JPSE_ST_GAP;
        end
      end
      JPSE_ST_GAP: begin
        next_idx = (idx == LAST_IDX) ? '0 : idx + IW'(1);
        next_state = JPSE_ST_PICK;
      end
      default: begin
        next_state = JPSE_ST_PICK;
        next_canTxValid = 1'b0;
      end
    endcase
  end

  // the request payload is the wanted group, least significant byte first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= JPSE_ST_PICK;
      idx <= '0;
      pendPgn <= '0;
      pendDest <= GLOBAL_ADDR;
      canTxValid <= 1'b0;
      canTxId <= '0;
      canTxData <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      pendPgn <= next_pendPgn;
      pendDest <= next_pendDest;
      // only scan requests use this port; host-built frames are merged outside the block
      canTxValid <= next_canTxValid;
      canTxId <= next_canTxId;
      canTxData <= next_canTxData;
    end
  end

  // forwarding: a reply outranks a monitor hit for the same frame
  // the record fields hold between pulses so the host may read them late
  always_comb begin
    next_hostValid = 1'b0;
    next_hostIdx = hostIdx;
    next_hostPgn = hostPgn;
    next_hostSrc = hostSrc;
    next_hostDlc = hostDlc;
    next_hostData = hostData;
    if (replyHit) begin
      next_hostValid = 1'b1;
      next_hostIdx = idx;
    end else if (rxOk && monHit) begin
      next_hostValid = 1'b1;
      next_hostIdx = monIdx;
    end
    if (next_hostValid) begin
      next_hostPgn = rxPgn;
      next_hostSrc = rxSrc;
      next_hostDlc = canRxDlc;
      next_hostData = canRxData;
    end
  end

  // no host back-pressure: the record stands until the next forwarded frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hostValid <= 1'b0;
      hostIdx <= '0;
      hostPgn <= '0;
      hostSrc <= '0;
      hostDlc <= '0;
      hostData <= '0;
    end else begin
      hostValid <= next_hostValid;
      hostIdx <= next_hostIdx;
      hostPgn <= next_hostPgn;
      hostSrc <= next_hostSrc;
      hostDlc <= next_hostDlc;
      hostData <= next_hostData;
    end
  end

  // traffic is any good received frame or any accepted transmission
  assign trafficSeen = rxOk || (canTxValid && canTxReady);

  // stretch single frames so the flash is visible to the eye
  // back-to-back traffic keeps reloading, so a busy bus shows a steady light
  jpse_timer #(
    .W(LW)
  ) u_flashTimer (
    .clk(clk),
    .rst_b(rst_b),
    .load(trafficSeen),
    .loadVal(LW'(LED_FLASH_CYC)),
    .cancel(1'b0),
    .busy(ledBusy),
    .expired()
  );

  // indicators and fixed link settings, all registered
  // health is plain not-bus-off, one cycle late; no fault is latched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ledGreen <= 1'b0;
      ledOrange <= 1'b0;
      canBitCycles <= '0;
      canTxExt <= 1'b0;
      canTxDlc <= '0;
    end else begin
      ledGreen <= !canBusOff;
      ledOrange <= ledBusy;
      canBitCycles <= BIT_CYC_W'(BIT_CYCLES);
      canTxExt <= 1'b1;
      canTxDlc <= REQ_DLC;
    end
  end

endmodule

// ### hdl/jpse_timer.sv
// loadable down counter with busy level and one-cycle expiry pulse
module jpse_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic cancel,
  output logic busy,
  output logic expired
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // load wins over cancel so a fresh start is never swallowed
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = loadVal;
    end else if (cancel) begin
      next_count = '0;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);
  assign expired = (count == W'(1)) && !load && !cancel;

endmodule
